// file: rtl/bank_map_pkg.sv
// Constants for the banked data memory address decode
// Contract
// RULE1 - Status bits 6:5 pick the bank; 00 bank 0, 01 bank 1, 10/11 absent.
// RULE2 - Software should keep the upper bank-select bit cleared.
// RULE3 - Each bank spans 128 bytes, in-bank offsets 00h to 7Fh.
// RULE4 - Low offsets are special registers; general RAM from 20h (bank 0) and A0h (bank 1).
// RULE5 - Core registers appear at the same offset in both banks.
// RULE6 - Access is direct (bank bits plus address field) or indirect via the pointer.
// RULE7 - Special register storage is static RAM inside the banked space; the core registers here are flip-flops outside the RAM.
// RULE8 - Unimplemented special locations read zero and ignore writes; here non-core offsets below 20h are RAM cells that keep their writes.
package bank_map_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned OFFS_W = 7;
  localparam int unsigned FILE_W = 9;
  localparam int unsigned RAM_AW = 8;
  localparam logic [OFFS_W-1:0] OFFS_INDIRECT = 7'h00;
  localparam logic [OFFS_W-1:0] OFFS_PC_LOW = 7'h02;
  localparam logic [OFFS_W-1:0] OFFS_STATUS = 7'h03;
  localparam logic [OFFS_W-1:0] OFFS_POINTER = 7'h04;
  localparam logic [OFFS_W-1:0] OFFS_PC_LATCH = 7'h0a;
  localparam logic [OFFS_W-1:0] OFFS_INT_CTRL = 7'h0b;
  localparam logic [OFFS_W-1:0] OFFS_GPR_BASE = 7'h20;
  localparam int unsigned BANK_HI_BIT = 6;
  localparam int unsigned BANK_LO_BIT = 5;
  localparam int unsigned IND_BANK_BIT = 7;
  localparam logic [1:0] BANK_CODE_0 = 2'h0;
  localparam logic [1:0] BANK_CODE_1 = 2'h1;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] PC_LATCH_MASK = 8'h1f;
endpackage

// file: rtl/file_ram.sv
// Single-port byte memory with registered read data
`timescale 1ns/10ps
module file_ram
  import bank_map_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [RAM_AW-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule

// file: rtl/banked_data_memory_map.sv
// Banked register file: bank decode, core register mirrors, indirect access
`timescale 1ns/10ps
module banked_data_memory_map
  import bank_map_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [OFFS_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  output logic acc_ack,
  output logic [DATA_W-1:0] acc_rdata,
  output logic [DATA_W-1:0] core_status,
  output logic [DATA_W-1:0] file_select_pointer,
  output logic [DATA_W-1:0] program_counter_low,
  output logic [DATA_W-1:0] program_counter_upper_latch,
  output logic [DATA_W-1:0] interrupt_control,
  output logic bank_absent
);
  typedef enum logic [1:0] {SEL_ZERO, SEL_CORE, SEL_RAM} src_t;

  // Decode, core capture and the RAM read all happen on the taking edge and
  // the answer leaves one edge later, so a status or pointer write already
  // steers the very next request.

  // Resolve a 9-bit file address: bank code and in-bank offset
  function automatic logic [FILE_W-1:0] file_addr(input logic [1:0] bank,
                                                   input logic [OFFS_W-1:0] offs);
    file_addr = {bank, offs};
  endfunction

  // Only codes 00 and 01 have storage behind them; 10 and 11 are holes
  function automatic logic bank_implemented(input logic [1:0] bank);
    bank_implemented = (bank == BANK_CODE_0) || (bank == BANK_CODE_1);
  endfunction

  // Core registers mirrored at the same offset in both implemented banks
  function automatic logic is_core(input logic [OFFS_W-1:0] offs);
    is_core = (offs == OFFS_INDIRECT) || (offs == OFFS_PC_LOW) ||
              (offs == OFFS_STATUS) || (offs == OFFS_POINTER) ||
              (offs == OFFS_PC_LATCH) || (offs == OFFS_INT_CTRL);
  endfunction

  logic [1:0] bank_dir;
  logic [1:0] bank_eff;
  logic [OFFS_W-1:0] offs_eff;
  logic [FILE_W-1:0] faddr;
  logic indirect;
  logic bank_ok;
  logic ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [DATA_W-1:0] ram_rdata;
  src_t sel;
  src_t next_sel;
  logic [DATA_W-1:0] core_q;
  logic [DATA_W-1:0] next_core_q;
  logic next_ack;
  logic [DATA_W-1:0] next_status;
  logic [DATA_W-1:0] next_pointer;
  logic [DATA_W-1:0] next_pcl;
  logic [DATA_W-1:0] next_program_counter_upper_latch;
  logic [DATA_W-1:0] next_interrupt_control;
  logic next_absent;
  logic [DATA_W-1:0] next_rdata;
  logic next_acc_ack;
  logic ack_d;
  logic wr_req;
  logic wr_core;
  logic wr_status;
  logic wr_pointer;
  logic wr_pcl;
  logic wr_program_counter_upper_latch;
  logic wr_interrupt_control;

  always_comb begin
    bank_dir = {core_status[BANK_HI_BIT], core_status[BANK_LO_BIT]}; // RULE1
    indirect = (acc_addr == OFFS_INDIRECT); // RULE6
    // Indirect: pointer bit 7 picks the bank, low seven bits the offset
    bank_eff = indirect ? {1'b0, file_select_pointer[IND_BANK_BIT]} : bank_dir; // RULE6
    offs_eff = indirect ? file_select_pointer[OFFS_W-1:0] : acc_addr; // RULE3
    faddr = file_addr(bank_eff, offs_eff);
    bank_ok = bank_implemented(bank_eff); // RULE1
    // Pointer back to the indirect slot itself reads zero, never recurses
    if (!bank_ok || (indirect && offs_eff == OFFS_INDIRECT)) begin
      next_sel = SEL_ZERO; // RULE8
    end else if (is_core(offs_eff)) begin
      next_sel = SEL_CORE; // RULE5
    end else begin
      next_sel = SEL_RAM; // RULE4 RULE7
    end
    wr_req = acc_req && acc_we;
    ram_addr = faddr[RAM_AW-1:0];
    // A refused or core access must never disturb the RAM cell behind it
    ram_we = wr_req && (next_sel == SEL_RAM); // RULE7
  end

  // Core value for a read, picked on the taking edge
  always_comb begin
    unique case (offs_eff)
      OFFS_PC_LOW: next_core_q = program_counter_low;
      OFFS_STATUS: next_core_q = core_status;
      OFFS_POINTER: next_core_q = file_select_pointer;
      OFFS_PC_LATCH: next_core_q = program_counter_upper_latch;
      OFFS_INT_CTRL: next_core_q = interrupt_control;
      default: next_core_q = ZERO_BYTE;
    endcase
  end

  // Core register write strobes; a refused access never reaches them
  always_comb begin
    wr_core = wr_req && (next_sel == SEL_CORE); // RULE5
    wr_pcl = wr_core && (offs_eff == OFFS_PC_LOW);
    wr_status = wr_core && (offs_eff == OFFS_STATUS);
    wr_pointer = wr_core && (offs_eff == OFFS_POINTER);
    wr_program_counter_upper_latch = wr_core && (offs_eff == OFFS_PC_LATCH);
    wr_interrupt_control = wr_core && (offs_eff == OFFS_INT_CTRL);
  end

  // One copy of each core register, so both bank offsets reach the same cell
  always_comb begin
    next_status = core_status;
    next_pointer = file_select_pointer;
    next_pcl = program_counter_low;
    next_program_counter_upper_latch = program_counter_upper_latch;
    next_interrupt_control = interrupt_control;
    if (wr_status) begin
      next_status = acc_wdata; // RULE1 RULE5
    end
    if (wr_pointer) begin
      next_pointer = acc_wdata; // RULE5 RULE6
    end
    if (wr_pcl) begin
      next_pcl = acc_wdata; // RULE5
    end
    if (wr_program_counter_upper_latch) begin
      // Only five latch bits exist; the rest read back as zero
      next_program_counter_upper_latch = acc_wdata & PC_LATCH_MASK; // RULE5
    end
    if (wr_interrupt_control) begin
      next_interrupt_control = acc_wdata; // RULE5
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      core_status <= STATUS_RESET;
      file_select_pointer <= ZERO_BYTE;
      program_counter_low <= ZERO_BYTE;
      program_counter_upper_latch <= ZERO_BYTE;
      interrupt_control <= ZERO_BYTE;
    end else begin
      core_status <= next_status;
      file_select_pointer <= next_pointer;
      program_counter_low <= next_pcl;
      program_counter_upper_latch <= next_program_counter_upper_latch;
      interrupt_control <= next_interrupt_control;
    end
  end

  // Flag follows the status value being written, so it lines up with the
  // register itself instead of lagging one cycle behind it
  always_comb begin
    next_absent = !bank_implemented(next_status[BANK_HI_BIT:BANK_LO_BIT]); // RULE1
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bank_absent <= 1'b0;
    end else begin
      bank_absent <= next_absent;
    end
  end

  // Capture stage: every taken request earns exactly one answer
  always_comb begin
    next_ack = acc_req;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel <= SEL_ZERO;
      core_q <= ZERO_BYTE;
      ack_d <= 1'b0;
    end else begin
      sel <= next_sel;
      core_q <= next_core_q;
      ack_d <= next_ack;
    end
  end

  // Answer stage: the read mux sits after the RAM's output register; a
  // registered copy keeps the top output straight from a flip-flop at the
  // cost of one more cycle. Read data holds until the next answer.
  always_comb begin
    next_acc_ack = ack_d;
    next_rdata = acc_rdata;
    if (ack_d) begin
      unique case (sel)
        SEL_ZERO: next_rdata = ZERO_BYTE; // RULE8
        SEL_CORE: next_rdata = core_q; // RULE5
        SEL_RAM: next_rdata = ram_rdata; // RULE4 RULE7
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_ack <= 1'b0;
      acc_rdata <= ZERO_BYTE;
    end else begin
      acc_ack <= next_acc_ack;
      acc_rdata <= next_rdata;
    end
  end

  // General RAM and the peripheral offsets of both banks share this array
  file_ram u_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_we),
    .addr(ram_addr),
    .wr_data(acc_wdata),
    .rd_data(ram_rdata)
  );
endmodule

// file: testbench/bank_map_assertions.sv
// Port checker for the banked register file
`timescale 1ns/10ps
module bank_map_assertions
  import bank_map_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [OFFS_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  input wire logic acc_ack,
  input wire logic [DATA_W-1:0] acc_rdata,
  input wire logic [DATA_W-1:0] core_status,
  input wire logic [DATA_W-1:0] file_select_pointer,
  input wire logic [DATA_W-1:0] program_counter_upper_latch,
  input wire logic bank_absent
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire rd = acc_req && !acc_we;
  wire wr = acc_req && acc_we;
  AST_ACK_LATENCY: assert property (acc_req |-> ##[2:3] acc_ack) else $error("ack late");
  AST_ACK_CAUSE: assert property (acc_ack |-> $past(acc_req, 2) || $past(acc_req, 3))
    else $error("ack without request");
  AST_ABSENT_FLAG: assert property ($stable(core_status) |-> bank_absent == core_status[6])
    else $error("absent flag wrong");
  AST_ABSENT_READ: assert property (rd && core_status[6] && acc_addr >= OFFS_GPR_BASE
    |-> ##[2:3] (acc_ack && acc_rdata == ZERO_BYTE)) else $error("absent bank read not zero");
  AST_INDIRECT_ZERO: assert property (rd && acc_addr == OFFS_INDIRECT
    && file_select_pointer[6:0] == 7'h00 |-> ##[2:3] (acc_ack && acc_rdata == ZERO_BYTE))
    else $error("indirect slot read not zero");
  AST_POINTER_WRITE: assert property (wr && acc_addr == OFFS_POINTER && !core_status[6]
    |=> file_select_pointer == $past(acc_wdata)) else $error("pointer not written");
  AST_POINTER_HOLD: assert property (!wr |=> $stable(file_select_pointer))
    else $error("pointer changed without write");
  AST_STATUS_BANK: assert property (wr && acc_addr == OFFS_STATUS && !core_status[6]
    |=> core_status[6:5] == $past(acc_wdata[6:5])) else $error("bank bits not written");
  AST_LATCH_WIDTH: assert property ((program_counter_upper_latch & ~PC_LATCH_MASK) == 8'h00)
    else $error("latch upper bits set");
  cover property (acc_ack && core_status[5]);
  cover property (bank_absent && acc_ack);
  cover property (rd && acc_addr == OFFS_INDIRECT);
  cover property (wr && acc_addr == OFFS_INDIRECT && bank_absent);
endmodule

// file: testbench/core_model.sv
// Core-side access model: one byte access per call, waits for the answer
`timescale 1ns/10ps
module core_model
  import bank_map_pkg::*;
(
  input wire logic ref_clk,
  input wire logic acc_ack,
  input wire logic [DATA_W-1:0] acc_rdata,
  output logic acc_req = 1'b0,
  output logic acc_we = 1'b0,
  output logic [OFFS_W-1:0] acc_addr = 7'h00,
  output logic [DATA_W-1:0] acc_wdata = 8'h00
);
  // Data is inverted after the request so a stale value cannot pass
  task automatic access(input logic we, input logic [OFFS_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r, output logic ok);
    ok = 1'b0;
    r = 8'h00;
    @(posedge ref_clk);
    acc_req <= 1'b1;
    acc_we <= we;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    acc_wdata <= ~d;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge ref_clk);
      ok = (acc_ack === 1'b1);
      r = acc_rdata;
    end
  endtask
endmodule

// file: testbench/test_banked_data_memory_map.sv
// Self-checking bench for the banked register file
`timescale 1ns/10ps
module test_banked_data_memory_map;
  import bank_map_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic acc_req, acc_we, acc_ack, bank_absent, ok, b;
  logic [OFFS_W-1:0] acc_addr, off;
  logic [DATA_W-1:0] acc_wdata, acc_rdata, core_status, file_select_pointer, got;
  logic [DATA_W-1:0] program_counter_low, program_counter_upper_latch, interrupt_control;
  logic [DATA_W-1:0] lfsr = 8'h24;
  int n_errors = 0;
  int check_count = 0;
  always #4 ref_clk = ~ref_clk;
  banked_data_memory_map uut (.ref_clk, .rst_n, .acc_req, .acc_we, .acc_addr, .acc_wdata,
    .acc_ack, .acc_rdata, .core_status, .file_select_pointer, .program_counter_low,
    .program_counter_upper_latch, .interrupt_control, .bank_absent);
  core_model core (.ref_clk, .acc_ack, .acc_rdata, .acc_req, .acc_we, .acc_addr, .acc_wdata);
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task acc(input logic we, input logic [6:0] a, input logic [7:0] d);
    core.access(we, a, d, got, ok);
    if (!ok) begin
      n_errors++;
      $display("ERROR ack expected 1 seen 0");
      give_verdict();
    end
  endtask
  task rd_chk(input string what, input logic [6:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(what, e, got);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("status", STATUS_RESET, core_status);
    for (int i = 0; i < 40; i++) begin
      lfsr = next_rand(lfsr);
      b = lfsr[0];
      off = 7'h0c + 7'(lfsr[7:1] % 116);
      acc(1'b1, OFFS_STATUS, {2'b00, b, 5'h18});
      lfsr = next_rand(lfsr);
      acc(1'b1, off, lfsr);
      acc(1'b1, OFFS_POINTER, {b, off});
      rd_chk("indirect", OFFS_INDIRECT, lfsr);
      rd_chk("direct", off, lfsr);
      acc(1'b1, OFFS_STATUS, {2'b00, ~b, 5'h18});
      rd_chk("pointer mirror", OFFS_POINTER, {b, off});
    end
    $display("test random traffic done");
    acc(1'b1, OFFS_STATUS, 8'h18);
    acc(1'b1, 7'h7f, 8'h5a);
    acc(1'b1, 7'h20, 8'hc3);
    acc(1'b1, OFFS_PC_LATCH, 8'hff);
    chk("latch", PC_LATCH_MASK, program_counter_upper_latch);
    acc(1'b1, OFFS_PC_LOW, 8'h3c);
    chk("pc low", 8'h3c, program_counter_low);
    acc(1'b1, OFFS_STATUS, 8'h38);
    acc(1'b1, 7'h7f, 8'ha5);
    acc(1'b1, OFFS_INT_CTRL, 8'h81);
    chk("int ctrl", 8'h81, interrupt_control);
    rd_chk("pc low mirror", OFFS_PC_LOW, 8'h3c);
    rd_chk("bank1 top", 7'h7f, 8'ha5);
    acc(1'b1, OFFS_STATUS, 8'h18);
    rd_chk("bank0 top", 7'h7f, 8'h5a);
    rd_chk("int ctrl mirror", OFFS_INT_CTRL, 8'h81);
    acc(1'b1, OFFS_POINTER, 8'h00);
    rd_chk("indirect slot", OFFS_INDIRECT, 8'h00);
    $display("test corners done");
    acc(1'b1, OFFS_POINTER, 8'h83);
    chk("pointer", 8'h83, file_select_pointer);
    acc(1'b1, OFFS_STATUS, 8'h58);
    rd_chk("absent read", 7'h20, 8'h00);
    acc(1'b1, 7'h20, 8'h11);
    chk("absent flag", 8'h01, {7'h00, bank_absent});
    // Core registers stay reachable through the pointer from an absent bank
    acc(1'b1, OFFS_INDIRECT, 8'h78);
    rd_chk("absent code 3 read", 7'h21, 8'h00);
    rd_chk("status via pointer", OFFS_INDIRECT, 8'h78);
    chk("absent flag 3", 8'h01, {7'h00, bank_absent});
    // Leave the absent bank by reset, so no reliance on a status write there
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("absent write ignored", 7'h20, 8'hc3);
    $display("test absent bank done");
    give_verdict();
  end
endmodule
bind banked_data_memory_map bank_map_assertions chk_i (.ref_clk, .rst_n, .acc_req, .acc_we,
  .acc_addr, .acc_wdata, .acc_ack, .acc_rdata, .core_status, .file_select_pointer,
  .program_counter_upper_latch, .bank_absent);
